// *** hdl/empm_part_dec.sv ***
// Partition decoder: code or address count to pin enables
`timescale 1ns/1ps
module empm_part_dec (
    // Selection
    input  wire logic [3:0]           code,
    input  wire logic                 custom,
    input  wire logic [4:0]           naddr,
    input  wire logic                 wide,
    // Result
    output empm_pkg::empm_part_s      part
);
    //==========================================================================
    // Count-based mask, contiguous from bank bit 1
    //==========================================================================
    function automatic logic [15:0] run_mask(input logic [4:0] n);
        logic [15:0] m;
        m = 16'h0000;
        for (int i = 0; i < 16; i++) begin
            if (i < int'(n)) begin
                m[i] = 1'b1;
            end
        end
        return m;
    endfunction

    // Order of the run: BA1, A0, A1..A13, BA0 as top
    logic [15:0] cnt_mask;
    assign cnt_mask = run_mask((naddr > 5'(empm_pkg::NADDR_MAX)) ? 5'(empm_pkg::NADDR_MAX) : naddr);

    empm_pkg::empm_part_s code_part;
    empm_pkg::empm_part_s cnt_part;

    // Strap-style decode of the table codes
    always_comb begin
        code_part = '0;
        code_part.addr_en = 14'h0006;
        case (code)
            empm_pkg::CODE_NAND: begin
                code_part.wide = 1'b0;
            end
            empm_pkg::CODE_C: begin
                code_part.addr_en = 14'h3fff;
                code_part.ba1_en  = 1'b1;
            end
            empm_pkg::CODE_A, empm_pkg::CODE_CNAND: begin
                code_part.addr_en    = 14'h3fff;
                code_part.ba1_en     = 1'b1;
                code_part.ba0_en     = 1'b1;
                code_part.ba0_is_a14 = 1'b1;
                code_part.data_hi_en = (code == empm_pkg::CODE_CNAND);
                code_part.wide       = (code == empm_pkg::CODE_CNAND);
            end
            empm_pkg::CODE_SRAM8, empm_pkg::CODE_ZERO: begin
                code_part.addr_en    = 14'h3fff;
                code_part.ba1_en     = 1'b1;
                code_part.ba0_en     = 1'b1;
                code_part.data_hi_en = (code == empm_pkg::CODE_ZERO);
                code_part.wide       = (code == empm_pkg::CODE_ZERO);
            end
            default: begin
                code_part.addr_en = 14'h0006;         // Other codes: NAND minimum
            end
        endcase
    end

    // Count-based decode, software-only selections
    always_comb begin
        cnt_part            = '0;
        cnt_part.ba1_en     = cnt_mask[0];
        cnt_part.addr_en    = cnt_mask[14:1] | 14'h0006;
        cnt_part.ba0_en     = cnt_mask[15];
        cnt_part.ba0_is_a14 = cnt_mask[15] & wide;
        cnt_part.data_hi_en = wide;
        cnt_part.wide       = wide;
    end

    assign part = custom ? cnt_part : code_part;
endmodule

// *** hdl/empm_pin_cell.sv ***
// Pin cell: chooses memory or GPIO drive for one shared pin
`timescale 1ns/1ps
module empm_pin_cell (
    // Selection
    input  wire logic mem_sel,
    // Memory side
    input  wire logic mem_out,
    input  wire logic mem_oe,
    // GPIO side
    input  wire logic gpio_out,
    input  wire logic gpio_oe,
    // Pad
    output logic      pad_out,
    output logic      pad_oe
);
    // Shared pin goes to GPIO when not claimed
    assign pad_out = mem_sel ? mem_out : gpio_out;
    assign pad_oe  = mem_sel ? mem_oe  : gpio_oe;
endmodule

// *** hdl/empm_pkg.sv ***
// Package for the external memory pin mux: register map, fields, partition codes
//==========================================================================
//==========================================================================
package empm_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_VIDEO_IN  = 8'h00;
    localparam logic [7:0] OFS_VIDEO_OUT = 8'h04;
    localparam logic [7:0] OFS_MEMIF     = 8'h08;
    localparam logic [7:0] OFS_GIO       = 8'h0c;
    localparam logic [7:0] OFS_SPI_CARD  = 8'h10;
    localparam logic [7:0] OFS_STATUS    = 8'h14;

    // Memory mux register fields
    localparam int MEMIF_CODE_LSB   = 0;   // Partition code [3:0]
    localparam int MEMIF_RATE_BIT   = 4;   // Full-rate flag
    localparam int MEMIF_WIDTH_BIT  = 5;   // 1 = 16-bit data
    localparam int MEMIF_NADDR_LSB  = 8;   // Address count [12:8]
    localparam int MEMIF_CUSTOM_BIT = 16;  // Use address count, not code

    // Reset values
    localparam logic [31:0] RST_MUX     = 32'h0000_0000;
    localparam logic [3:0]  STRAP_DFLT  = 4'b1101; // Pull default, NAND

    // Partition codes
    localparam logic [3:0] CODE_NAND    = 4'b1101;
    localparam logic [3:0] CODE_C       = 4'b1100;
    localparam logic [3:0] CODE_A       = 4'b1010;
    localparam logic [3:0] CODE_SRAM8   = 4'b1000;
    localparam logic [3:0] CODE_CNAND   = 4'b0010;
    localparam logic [3:0] CODE_ZERO    = 4'b0000;

    // Pin counts
    localparam int NADDR_MAX   = 16;
    localparam int NPIN_ADDR   = 16;  // A0..A13, BA0, BA1
    localparam int NPIN_DATA   = 8;   // Upper data byte

    // Group function selections
    typedef enum logic [1:0] {
        EMPM_FN_PRIMARY   = 2'b00,
        EMPM_FN_SECONDARY = 2'b01,
        EMPM_FN_TERTIARY  = 2'b10,
        EMPM_FN_GPIO      = 2'b11
    } empm_fn_e;

    // Decoded partition of the shared pins
    typedef struct packed {
        logic [13:0] addr_en;    // A13..A0 as address
        logic        ba1_en;     // Bank bit 1 as address
        logic        ba0_en;     // Bank bit 0 pin as memory
        logic        ba0_is_a14; // Bank bit 0 pin carries A14
        logic        data_hi_en; // Data 8..15 enabled
        logic        wide;       // 16-bit data mode
    } empm_part_s;

endpackage

// *** hdl/empm_top.sv ***
// Top of the external memory pin mux with its AXI4-Lite register file
//
// Design decisions made here: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module empm_top #(
    parameter int NADDR_PINS = 16
) (
    // Clock and reset
    input  wire logic                 ref_clk,
    input  wire logic                 rst_b,
    // Strap pins, sampled after reset release
    input  wire logic [3:0]           memif_cfg_strap,
    input  wire logic                 strap_driven,
    // AXI4-Lite write address
    input  wire logic [7:0]           s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]                s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    // AXI4-Lite read
    input  wire logic [7:0]           s_axi_araddr,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    // Memory interface side of shared pins
    input  wire logic [15:0]          mem_addr_out,
    input  wire logic [15:0]          mem_addr_oe,
    input  wire logic [7:0]           mem_data_out,
    input  wire logic [7:0]           mem_data_oe,
    // GPIO side of shared pins
    input  wire logic [15:0]          gpio_addr_out,
    input  wire logic [15:0]          gpio_addr_oe,
    input  wire logic [7:0]           gpio_data_out,
    input  wire logic [7:0]           gpio_data_oe,
    // Pads
    output logic [15:0]               ext_addr_pin_out,
    output logic [15:0]               ext_addr_pin_oe,
    output logic [7:0]                ext_data_pin_out,
    output logic [7:0]                ext_data_pin_oe,
    // Decoded selections
    output empm_pkg::empm_part_s      part,
    output logic                      strap_done,
    output logic [1:0]                video_in_fn,
    output logic [1:0]                video_out_fn,
    output logic [1:0]                card_fn,
    output logic                      memif_full_rate
);
    //==========================================================================
    // Registers
    //==========================================================================
    logic [31:0] video_in_mux_reg;
    logic [31:0] video_out_mux_reg;
    logic [31:0] memif_mux_reg;
    logic [31:0] gio_mux_reg;
    logic [31:0] spi_card_mux_reg;

    // Strap catch on first clock after reset, never under reset
    logic       strap_pend;
    logic [3:0] strap_val;
    assign strap_val = strap_driven ? memif_cfg_strap : empm_pkg::STRAP_DFLT;

    // Write channel: take address and data in either order
    logic       aw_held;
    logic       w_held;
    logic [7:0] aw_q;
    logic [31:0] w_q;
    logic [3:0] ws_q;
    assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
    wire       aw_now  = s_axi_awvalid & s_axi_awready;
    wire       w_now   = s_axi_wvalid & s_axi_wready;
    wire       aw_have = aw_held | aw_now;
    wire       w_have  = w_held | w_now;
    wire       wr_go   = aw_have & w_have;
    wire [7:0] wr_addr = aw_held ? aw_q : s_axi_awaddr;
    wire [31:0] wr_dat = w_held ? w_q : s_axi_wdata;
    wire [3:0] wr_stb  = w_held ? ws_q : s_axi_wstrb;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (st[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return r;
    endfunction

    wire wr_vi  = wr_go & (wr_addr == empm_pkg::OFS_VIDEO_IN);
    wire wr_vo  = wr_go & (wr_addr == empm_pkg::OFS_VIDEO_OUT);
    wire wr_mem = wr_go & (wr_addr == empm_pkg::OFS_MEMIF);
    wire wr_gio = wr_go & (wr_addr == empm_pkg::OFS_GIO);
    wire wr_spi = wr_go & (wr_addr == empm_pkg::OFS_SPI_CARD);
    wire wr_hit = wr_vi | wr_vo | wr_mem | wr_gio | wr_spi;

    // Register update; strap load beats a memif write in the same cycle
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            strap_pend        <= 1'b1;
            video_in_mux_reg  <= empm_pkg::RST_MUX;
            video_out_mux_reg <= empm_pkg::RST_MUX;
            memif_mux_reg     <= empm_pkg::RST_MUX;
            gio_mux_reg       <= empm_pkg::RST_MUX;
            spi_card_mux_reg  <= empm_pkg::RST_MUX;
        end else begin
            strap_pend <= 1'b0;
            if (strap_pend) begin
                memif_mux_reg[empm_pkg::MEMIF_CODE_LSB +: 4] <= strap_val;
            end else if (wr_mem) begin
                memif_mux_reg <= merge(memif_mux_reg, wr_dat, wr_stb);
            end
            if (wr_vi)  video_in_mux_reg  <= merge(video_in_mux_reg, wr_dat, wr_stb);
            if (wr_vo)  video_out_mux_reg <= merge(video_out_mux_reg, wr_dat, wr_stb);
            if (wr_gio) gio_mux_reg       <= merge(gio_mux_reg, wr_dat, wr_stb);
            if (wr_spi) spi_card_mux_reg  <= merge(spi_card_mux_reg, wr_dat, wr_stb);
        end
    end

    // Write handshake state
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            aw_q         <= 8'h00;
            w_q          <= 32'h0000_0000;
            ws_q         <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'b00;
        end else begin
            if (wr_go) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? 2'b00 : 2'b10;
            end else begin
                if (aw_now) begin
                    aw_held <= 1'b1;
                    aw_q    <= s_axi_awaddr;
                end
                if (w_now) begin
                    w_held <= 1'b1;
                    w_q    <= s_axi_wdata;
                    ws_q   <= s_axi_wstrb;
                end
                if (s_axi_bvalid && s_axi_bready) begin
                    s_axi_bvalid <= 1'b0;
                end
            end
        end
    end

    //==========================================================================
    // Read channel
    //==========================================================================
    assign s_axi_arready = ~s_axi_rvalid;
    logic [31:0] rd_mux;
    logic        rd_hit;
    always_comb begin
        rd_hit = 1'b1;
        case (s_axi_araddr)
            empm_pkg::OFS_VIDEO_IN:  rd_mux = video_in_mux_reg;
            empm_pkg::OFS_VIDEO_OUT: rd_mux = video_out_mux_reg;
            empm_pkg::OFS_MEMIF:     rd_mux = memif_mux_reg;
            empm_pkg::OFS_GIO:       rd_mux = gio_mux_reg;
            empm_pkg::OFS_SPI_CARD:  rd_mux = spi_card_mux_reg;
            empm_pkg::OFS_STATUS:    rd_mux = {9'h000, part.wide, part.data_hi_en, part.ba0_is_a14,
                                               part.ba0_en, part.ba1_en, part.addr_en, 3'h0, ~strap_pend};
            default: begin
                rd_mux = 32'h0000_0000;
                rd_hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= 2'b00;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_mux;
            s_axi_rresp  <= rd_hit ? 2'b00 : 2'b10;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    //==========================================================================
    // Partition decode and pin steering; no suitability
    //==========================================================================
    empm_part_dec u_dec (
        .code   (memif_mux_reg[empm_pkg::MEMIF_CODE_LSB +: 4]),
        .custom (memif_mux_reg[empm_pkg::MEMIF_CUSTOM_BIT]),
        .naddr  (memif_mux_reg[empm_pkg::MEMIF_NADDR_LSB +: 5]),
        .wide   (memif_mux_reg[empm_pkg::MEMIF_WIDTH_BIT]),
        .part   (part)
    );

    // Pin order: [13:0] A13..A0, [14] BA1, [15] BA0
    // Memory functions only after strap sampled
    logic [15:0] addr_sel;
    assign addr_sel = strap_pend ? 16'h0000 : {part.ba0_en, part.ba1_en, part.addr_en};

    for (genvar i = 0; i < 16; i++) begin : g_addr
        empm_pin_cell u_cell (
            .mem_sel  (addr_sel[i]),
            .mem_out  (mem_addr_out[i]),
            .mem_oe   (mem_addr_oe[i]),
            .gpio_out (gpio_addr_out[i]),
            .gpio_oe  (gpio_addr_oe[i]),
            .pad_out  (ext_addr_pin_out[i]),
            .pad_oe   (ext_addr_pin_oe[i])
        );
    end
    for (genvar j = 0; j < 8; j++) begin : g_data
        empm_pin_cell u_cell (
            .mem_sel  (part.data_hi_en & ~strap_pend),
            .mem_out  (mem_data_out[j]),
            .mem_oe   (mem_data_oe[j]),
            .gpio_out (gpio_data_out[j]),
            .gpio_oe  (gpio_data_oe[j]),
            .pad_out  (ext_data_pin_out[j]),
            .pad_oe   (ext_data_pin_oe[j])
        );
    end

    // Group function selects from software registers
    assign video_in_fn     = video_in_mux_reg[1:0];
    assign video_out_fn    = video_out_mux_reg[1:0];
    assign card_fn         = spi_card_mux_reg[1:0];
    assign memif_full_rate = memif_mux_reg[empm_pkg::MEMIF_RATE_BIT]; // Kept 0 by software
    assign strap_done      = ~strap_pend;

    //==========================================================================
    // Assertions
    //==========================================================================
    latch_pins_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        strap_done |-> addr_sel[2:1] == 2'b11) else $error("latch pins not enabled");
    strap_load_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        strap_pend |=> memif_mux_reg[3:0] == $past(strap_val)) else $error("strap not loaded");
    sw_write_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (wr_mem && !strap_pend && wr_stb[0]) |=> memif_mux_reg[3:0] == $past(wr_dat[3:0]))
        else $error("memif write lost");
    nand_part_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (strap_done && !part.wide && memif_mux_reg[3:0] == empm_pkg::CODE_NAND && !memif_mux_reg[16])
        |-> addr_sel == 16'h0006) else $error("nand partition wrong");
    // Bank 0 is the top of a custom run, so it implies every lower pin
    run_top_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (strap_done && memif_mux_reg[16] && addr_sel[15]) |-> addr_sel == 16'hffff)
        else $error("address run has a gap");
    data_hi_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        ext_data_pin_oe == (part.data_hi_en && strap_done ? mem_data_oe : gpio_data_oe))
        else $error("upper data steering");
    pre_strap_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        strap_pend |-> ext_addr_pin_oe == gpio_addr_oe) else $error("pins claimed early");
    bresp_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        wr_go |=> s_axi_bvalid) else $error("no write response");
    rresp_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid) else $error("no read response");
    write_c: cover property (@(posedge ref_clk) disable iff (!rst_b) wr_mem);
    read_c: cover property (@(posedge ref_clk) disable iff (!rst_b) s_axi_rvalid && s_axi_rready);
    custom_c: cover property (@(posedge ref_clk) disable iff (!rst_b) memif_mux_reg[16]);
endmodule

// *** sim/empm_board_model.sv ***
// Board-side model: strap resistors, memory controller and GPIO drivers
`timescale 1ns/1ps
module empm_board_model (
    // Bench control
    input  wire logic        ref_clk,
    input  wire logic [3:0]  code,
    input  wire logic        drive_strap,
    // Strap pins
    output logic [3:0]       memif_cfg_strap,
    output logic             strap_driven,
    // Drivers behind the shared pins
    output logic [15:0]      mem_addr_out,
    output logic [15:0]      mem_addr_oe,
    output logic [7:0]       mem_data_out,
    output logic [7:0]       mem_data_oe,
    output logic [15:0]      gpio_addr_out,
    output logic [15:0]      gpio_addr_oe,
    output logic [7:0]       gpio_data_out,
    output logic [7:0]       gpio_data_oe
);
    logic tog = 1'b0;
    // Pattern flips every cycle so a stuck pad cannot pass
    always @(posedge ref_clk) tog <= ~tog;
    // Undriven strap settles on the pull level
    assign memif_cfg_strap = drive_strap ? code : 4'b1101;
    assign strap_driven    = drive_strap;
    // Memory side drives, GPIO side listens, opposite levels
    assign mem_addr_out  = tog ? 16'h5a5a : 16'ha5a5;
    assign gpio_addr_out = ~mem_addr_out;
    assign mem_data_out  = mem_addr_out[7:0];
    assign gpio_data_out = ~mem_data_out;
    assign mem_addr_oe   = 16'hffff;
    assign mem_data_oe   = 8'hff;
    assign gpio_addr_oe  = 16'h0000;
    assign gpio_data_oe  = 8'h00;
endmodule

// *** sim/empm_top_test.sv ***
// Self-checking bench for the external memory pin mux
`timescale 1ns/1ps
module empm_top_test;
    // ==========================================================
    // Signals
    logic ref_clk, rst_b, strap_driven, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic strap_done, memif_full_rate, drv;
    logic [1:0]  s_axi_bresp, s_axi_rresp, video_in_fn, video_out_fn, card_fn, r;
    logic [3:0]  memif_cfg_strap, s_axi_wstrb, code;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, mem_data_out, mem_data_oe, gpio_data_out, gpio_data_oe;
    logic [7:0]  ext_data_pin_out, ext_data_pin_oe;
    logic [15:0] mem_addr_out, mem_addr_oe, gpio_addr_out, gpio_addr_oe, ext_addr_pin_out, ext_addr_pin_oe;
    logic [31:0] s_axi_wdata, s_axi_rdata, d, w;
    empm_pkg::empm_part_s part;
    int errors = 0, checks = 0, cycles = 0;
    logic [3:0]  codes [6] = '{4'b1101, 4'b1100, 4'b1010, 4'b1000, 4'b0010, 4'b0000};
    logic [15:0] masks [6] = '{16'h0006, 16'h7fff, 16'hffff, 16'hffff, 16'hffff, 16'hffff};
    logic [7:0]  fregs [3] = '{empm_pkg::OFS_VIDEO_IN, empm_pkg::OFS_VIDEO_OUT, empm_pkg::OFS_SPI_CARD};

    // ==========================================================
    // Design, board model, clock, timeout
    empm_top dut (.ref_clk, .rst_b, .memif_cfg_strap, .strap_driven, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .mem_addr_out, .mem_addr_oe, .mem_data_out,
        .mem_data_oe, .gpio_addr_out, .gpio_addr_oe, .gpio_data_out, .gpio_data_oe, .ext_addr_pin_out,
        .ext_addr_pin_oe, .ext_data_pin_out, .ext_data_pin_oe, .part, .strap_done, .video_in_fn,
        .video_out_fn, .card_fn, .memif_full_rate);
    empm_board_model board (.ref_clk, .code, .drive_strap(drv), .memif_cfg_strap, .strap_driven,
        .mem_addr_out, .mem_addr_oe, .mem_data_out, .mem_data_oe, .gpio_addr_out, .gpio_addr_oe,
        .gpio_data_out, .gpio_data_oe);
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    // Run needs a few hundred cycles; far above that is a hang
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            report_and_stop();
        end
    end

    // ==========================================================
    // Tasks
    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Both channels offered together, each dropped when taken
    task automatic axi_write(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
        @(posedge ref_clk);
        s_axi_awaddr <= a; s_axi_awvalid <= 1'b1; s_axi_wdata <= v; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
        do @(posedge ref_clk); while (!s_axi_bvalid);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic axi_read(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
        @(posedge ref_clk);
        s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
        do @(posedge ref_clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge ref_clk); while (!s_axi_rvalid);
        v = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    // Pads sampled mid-cycle, away from the launching edge
    task automatic check_pads(input logic [15:0] m);
        @(negedge ref_clk);
        cmp("addr_oe", {16'h0000, m}, {16'h0000, ext_addr_pin_oe});
        cmp("addr_out", {16'h0000, (m & mem_addr_out) | (~m & gpio_addr_out)}, {16'h0000, ext_addr_pin_out});
    endtask
    task automatic do_reset(input logic [3:0] c, input logic dr);
        @(posedge ref_clk);
        code <= c; drv <= dr; rst_b <= 1'b0;
        repeat (3) @(posedge ref_clk);
        check_pads(16'h0000);
        cmp("strap_done", 32'h0000_0000, {31'h0000_0000, strap_done});
        @(posedge ref_clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge ref_clk);
    endtask
    // Count order of a custom run: bank 1, then A0 to A13, then bank 0
    function automatic logic [15:0] cust_mask(input int n);
        logic [15:0] m;
        m = 16'h0006;
        for (int i = 0; i < n; i++) m[(i == 0) ? 14 : (i == 15) ? 15 : i - 1] = 1'b1;
        return m;
    endfunction
    task automatic report_and_stop;
        if (errors == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        rst_b = 1'b0; code = 4'h0; drv = 1'b1; s_axi_awaddr = 8'h00; s_axi_awvalid = 1'b0;
        s_axi_wdata = 32'h0000_0000; s_axi_wstrb = 4'hf; s_axi_wvalid = 1'b0; s_axi_bready = 1'b0;
        s_axi_araddr = 8'h00; s_axi_arvalid = 1'b0; s_axi_rready = 1'b0;
        // Every strap code, then a software switch to the next code
        for (int i = 0; i < 6; i++) begin
            do_reset(codes[i], 1'b1);
            check_pads(masks[i]);
            cmp("data_oe", (i >= 4) ? 32'h0000_00ff : 32'h0000_0000, {24'h00_0000, ext_data_pin_oe});
            cmp("data_out", {24'h00_0000, (i >= 4) ? mem_data_out : gpio_data_out}, {24'h00_0000, ext_data_pin_out});
            axi_read(empm_pkg::OFS_MEMIF, d, r);
            cmp("memif_code", {28'h000_0000, codes[i]}, {28'h000_0000, d[3:0]});
            axi_read(empm_pkg::OFS_STATUS, d, r);
            w = {9'h000, i >= 4, i >= 4, i == 2 || i == 4, masks[i], 3'b000, 1'b1};
            cmp("status", w, d & 32'h007f_fff1);
            axi_write(empm_pkg::OFS_MEMIF, {28'h000_0000, codes[(i + 1) % 6]}, r);
            check_pads(masks[(i + 1) % 6]);
        end
        do_reset(4'b0000, 1'b0);
        check_pads(16'h0006);
        // Address count from 0 to 16, alternating data width
        for (int n = 0; n <= 16; n++) begin
            w = 32'h0001_0000 | (32'(n) << empm_pkg::MEMIF_NADDR_LSB) | (32'(n % 2) << empm_pkg::MEMIF_WIDTH_BIT);
            axi_write(empm_pkg::OFS_MEMIF, w, r);
            cmp("bresp", 32'h0000_0000, {30'h0000_0000, r});
            check_pads(cust_mask(n));
            cmp("wide", 32'(n % 2), {31'h0000_0000, part.wide});
            axi_read(empm_pkg::OFS_MEMIF, d, r);
            cmp("memif_rb", w, d);
        end
        // Group selections, all four functions on the video and card groups, one on GIO
        for (int k = 0; k < 3; k++) begin
            for (int f = 0; f < 4; f++) begin
                axi_write(fregs[k], 32'(f), r);
                axi_read(fregs[k], d, r);
                cmp("fn_rb", 32'(f), d);
                cmp("fn_out", 32'(f), {30'h0000_0000, (k == 0) ? video_in_fn : (k == 1) ? video_out_fn : card_fn});
            end
        end
        axi_write(empm_pkg::OFS_GIO, 32'h0000_0003, r);
        axi_read(empm_pkg::OFS_GIO, d, r);
        cmp("gio_rb", 32'h0000_0003, d);
        // Unmapped place and read-only status
        axi_write(8'h18, 32'hffff_ffff, r);
        cmp("bresp_unm", 32'h0000_0002, {30'h0000_0000, r});
        axi_read(8'h18, d, r);
        cmp("rresp_unm", 32'h0000_0002, {30'h0000_0000, r});
        cmp("rdata_unm", 32'h0000_0000, d);
        axi_write(empm_pkg::OFS_STATUS, 32'h0000_0000, r);
        axi_read(empm_pkg::OFS_STATUS, d, r);
        cmp("status_ro", 32'h0000_0001, {31'h0000_0000, d[0]});
        // Rate flag follows the register; restored to half rate and reset
        axi_write(empm_pkg::OFS_MEMIF, 32'h0000_001d, r);
        cmp("full_rate", 32'h0000_0001, {31'h0000_0000, memif_full_rate});
        axi_write(empm_pkg::OFS_MEMIF, 32'h0000_000d, r);
        cmp("half_rate", 32'h0000_0000, {31'h0000_0000, memif_full_rate});
        do_reset(4'b1101, 1'b1);
        cmp("rate_rst", 32'h0000_0000, {31'h0000_0000, memif_full_rate});
        report_and_stop();
    end
endmodule
